// *** src/usx_datapath.sv ***
// Transmit and receive data path of a serial port, with the receive FIFO.
// Assumes control inputs come from logic on clk; serial pins are asynchronous.
// How it works
// (R1) Transmit enable takes over serial output pin
// (R2) Synchronous transmit uses serial clock pin
// (R3) Data write loads buffer, starting transmission
// (R4) Buffer moves to shifter when idle/after stop
// (R5) Shifter sends full frame at step rate
// (R6) Unused upper transmit bits ignored
// (R7) Ninth bit taken from control bit
// (R8) Data-empty flag high while buffer empty
// (R9) Software writes zero to data-empty position
// (R10) Data-empty interrupt requested while flag high
// (R11) Data write clears data-empty flag
// (R12) Complete flag set when frame out, buffer empty
// (R13) Complete flag cleared by service or write-one
// (R14) Complete interrupt requested while flag set
// (R15) Parity bit sent after data, before stop
// (R16) Disable waits for buffer and shifter, releases pin
// (R17) Receive enable takes over serial input pin
// (R18) Synchronous receive uses serial clock pin
// (R19) Valid start bit begins sampling of frame
// (R20) Second stop bit ignored by receiver
// (R21) First stop bit moves frame into buffer
// (R22) Unused upper received bits read zero
// (R23) Start low, then data least significant first
// (R24) Parity is data XOR, inverted when odd
// (R25) Idle line is high
// (R26) Double speed halves oversampling, 16 to 8
// (R27) Reset: empty set, complete clear, both disabled
`timescale 1ns/1ps

module usx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    // Pointers wrap naturally, so only powers of two are served
    if (DEPTH < 2 || (1 << PW) != DEPTH)
    begin : g_bad_depth
        $error("usx_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    wire push = inValid & inReady;
    wire pop = outValid & outReady;

    // Honest flags; reader stall makes the writer stall
    assign inReady = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];

    // Storage is written only, never reset
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    // Pointer and fill bookkeeping
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wrPtr <= wrPtr + PW'(1);
            if (pop)
                rdPtr <= rdPtr + PW'(1);
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : usx_fifo

module usx_datapath
    import usx_pkg::*;
#(
    parameter int DIV_W = BAUD_DIV_WIDTH,
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfgTxEnable,
    input wire logic cfgRxEnable,
    input wire logic cfgSync,
    input wire logic cfgClockMaster,
    input wire logic [2:0] cfgCharSize,
    input wire logic cfgParityEnable,
    input wire logic cfgParityOdd,
    input wire logic cfgTwoStop,
    input wire logic cfgDoubleSpeed,
    input wire logic [DIV_W-1:0] cfgBaudDiv,
    input wire logic globalIrqEnable,
    input wire logic dataEmptyIrqEnable,
    input wire logic txCompleteIrqEnable,
    input wire logic dataWrite,
    input wire logic [7:0] dataIn,
    input wire logic txNinth,
    input wire logic txCompleteClear,
    input wire logic txCompleteAck,
    output logic dataEmpty,
    output logic txComplete,
    output logic irqDataEmpty,
    output logic irqTxComplete,
    output logic rxValid,
    input wire logic rxReady,
    output logic [CHAR_BITS_MAX-1:0] rxData,
    output logic txdOut,
    output logic txdOwn,
    input wire logic rxdIn,
    output logic rxdOwn,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOeN
);
    if (DIV_W < 1 || DIV_W > 16)
    begin : g_bad_div
        $error("usx_datapath baud divider width out of range");
    end

    usx_tx_state_t txState;
    usx_rx_state_t rxState;
    logic [DIV_W-1:0] baudCnt;
    logic [4:0] txOs;
    logic [4:0] rxOs;
    logic [8:0] txBuf;
    logic txBufFull;
    logic [8:0] txShift;
    logic [3:0] txIdx;
    logic txParity;
    logic txOwn;
    logic [8:0] rxShift;
    logic [3:0] rxIdx;
    logic rxSync1;
    logic rxSync2;
    logic sckSync1;
    logic sckSync2;
    logic sckPrev;

    // Frame geometry from the character size code
    wire isNine = (cfgCharSize == CHAR_SIZE_NINE);
    wire isShort = (cfgCharSize <= CHAR_SIZE_LAST_SHORT);
    wire [3:0] charBits = isNine ? CHAR_BITS_NINE : isShort ? CHAR_BITS_BASE + {1'b0, cfgCharSize} : CHAR_BITS_EIGHT;
    wire [3:0] lastBit = charBits - 4'h1;
    wire [8:0] charMask = 9'h1FF >> (CHAR_BITS_NINE - charBits);
    wire [8:0] txWord = {txNinth, dataIn} & charMask; // [R6] [R7]

    // Oversampling ratio, halved in double speed
    wire [4:0] osrLast = cfgDoubleSpeed ? 5'(OSR_DOUBLE - 1) : 5'(OSR_NORMAL - 1); // [R26]
    wire [4:0] osHalfLast = cfgDoubleSpeed ? 5'(OSR_DOUBLE / 2 - 1) : 5'(OSR_NORMAL / 2 - 1);

    // Shared baud divider ticks, edges of the serial clock
    wire portActive = txOwn | cfgRxEnable;
    wire baudTick = portActive && (baudCnt == cfgBaudDiv);
    wire masterSck = cfgSync & cfgClockMaster;
    wire sckRise = cfgSync && (masterSck ? baudTick & ~sckOut : sckSync2 & ~sckPrev);
    wire sckFall = cfgSync && (masterSck ? baudTick & sckOut : ~sckSync2 & sckPrev);

    // Transmit bit steps: divided clock or serial clock rising edge
    wire txStep = cfgSync ? sckRise : (baudTick && txOs == osrLast); // [R2] [R5]
    wire txLastStop = txStep && ((txState == TX_STOP1 && !cfgTwoStop) || txState == TX_STOP2);
    wire txLoad = txOwn && txBufFull && txStep && (txState == TX_IDLE || txLastStop); // [R4]
    wire txDone = txLastStop && !txBufFull; // [R12]
    wire next_txOwn = cfgTxEnable | (txOwn & (txBufFull | txState != TX_IDLE)); // [R16]

    // Level the line shows for the current frame position
    wire txLine = (txState == TX_START) ? START_LEVEL : // [R23]
                  (txState == TX_DATA) ? txShift[0] :
                  (txState == TX_PARITY) ? txParity : LINE_IDLE; // [R15] [R25]

    // Receive sample points: middle of bit, or serial clock falling edge
    // Input synchroniser lag means a master clock needs a divider of 2 or more
    wire [4:0] rxTarget = (rxState == RX_START) ? osHalfLast : osrLast;
    wire rxSample = cfgSync ? sckFall : (baudTick && rxOs == rxTarget); // [R18] [R26]
    wire fifoInValid = (rxState == RX_STOP && rxSample) || rxState == RX_HOLD; // [R21]
    logic fifoInReady;

    // Flags, interrupt requests and pin ownership
    assign dataEmpty = ~txBufFull; // [R8]
    assign irqDataEmpty = globalIrqEnable & dataEmptyIrqEnable & dataEmpty; // [R10]
    assign irqTxComplete = globalIrqEnable & txCompleteIrqEnable & txComplete; // [R14]
    assign txdOwn = txOwn; // [R1]
    assign rxdOwn = cfgRxEnable; // [R17]
    assign sckOeN = ~(masterSck & portActive); // [R2]

    // Pin synchronisers; edge detector reads only the second stage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxSync1 <= LINE_IDLE;
            rxSync2 <= LINE_IDLE;
            sckSync1 <= 1'b0;
            sckSync2 <= 1'b0;
            sckPrev <= 1'b0;
        end
        else
        begin
            rxSync1 <= rxdIn;
            rxSync2 <= rxSync1;
            sckSync1 <= sckIn;
            sckSync2 <= sckSync1;
            sckPrev <= sckSync2;
        end
    end

    // Baud divider, transmit prescaler and master serial clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            baudCnt <= '0;
            txOs <= '0;
            sckOut <= 1'b0;
        end
        else
        begin
            baudCnt <= baudTick || !portActive ? '0 : baudCnt + DIV_W'(1);
            if (!portActive)
                txOs <= '0;
            else if (baudTick)
                txOs <= (txOs == osrLast) ? 5'h0 : txOs + 5'h1;
            if (!masterSck || !portActive)
                sckOut <= 1'b0;
            else if (baudTick)
                sckOut <= ~sckOut;
        end
    end

    // Transmit buffer, flags and pin ownership
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txBuf <= '0;
            txBufFull <= ~DATA_EMPTY_RESET; // [R27]
            txComplete <= TX_COMPLETE_RESET;
            txOwn <= 1'b0;
            txdOut <= LINE_IDLE;
        end
        else
        begin
            if (dataWrite)
            begin
                txBuf <= txWord; // [R3]
                txBufFull <= 1'b1; // [R11]
            end
            else if (txLoad)
                txBufFull <= 1'b0;
            // A completion in the same cycle as a clear is kept
            if (txDone)
                txComplete <= 1'b1;
            else if (txCompleteClear || txCompleteAck)
                txComplete <= 1'b0; // [R13]
            txOwn <= next_txOwn;
            txdOut <= txLine;
        end
    end

    // Transmit shifter walks the frame one bit step at a time
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txState <= TX_IDLE;
            txShift <= '0;
            txIdx <= '0;
            txParity <= 1'b0;
        end
        else if (txLoad)
        begin
            txState <= TX_START; // [R4]
            txShift <= txBuf;
            txIdx <= '0;
            txParity <= (^txBuf) ^ cfgParityOdd; // [R24]
        end
        else if (txStep)
        begin
            case (txState)
                TX_START:
                    txState <= TX_DATA;
                TX_DATA:
                begin
                    txShift <= txShift >> 1; // [R23]
                    txIdx <= txIdx + 4'h1;
                    if (txIdx == lastBit)
                        txState <= cfgParityEnable ? TX_PARITY : TX_STOP1; // [R15]
                end
                TX_PARITY:
                    txState <= TX_STOP1;
                TX_STOP1:
                    txState <= cfgTwoStop ? TX_STOP2 : TX_IDLE;
                TX_STOP2:
                    txState <= TX_IDLE;
                default:
                    txState <= TX_IDLE;
            endcase
        end
    end

    // Receiver: start detect, data sampling, hand-over to the FIFO
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxState <= RX_IDLE;
            rxOs <= '0;
            rxShift <= '0;
            rxIdx <= '0;
        end
        else if (!cfgRxEnable)
        begin
            rxState <= RX_IDLE; // [R27]
            rxOs <= '0;
        end
        else
        begin
            if (rxState == RX_IDLE || rxSample)
                rxOs <= '0;
            else if (baudTick)
                rxOs <= rxOs + 5'h1;
            case (rxState)
                RX_IDLE:
                begin
                    rxShift <= '0;
                    rxIdx <= '0;
                    // Synchronous mode samples the start bit on the clock edge
                    if (cfgSync && sckFall && rxSync2 == START_LEVEL)
                        rxState <= RX_DATA; // [R18] [R19]
                    else if (!cfgSync && baudTick && rxSync2 == START_LEVEL)
                        rxState <= RX_START;
                end
                RX_START:
                    // Mid-bit check rejects glitches as false starts
                    if (rxSample)
                        rxState <= (rxSync2 == START_LEVEL) ? RX_DATA : RX_IDLE; // [R19]
                RX_DATA:
                    if (rxSample)
                    begin
                        rxShift[rxIdx] <= rxSync2; // [R22] [R23]
                        rxIdx <= rxIdx + 4'h1;
                        if (rxIdx == lastBit)
                            rxState <= cfgParityEnable ? RX_PARITY : RX_STOP;
                    end
                RX_PARITY:
                    if (rxSample)
                        rxState <= RX_STOP;
                RX_STOP:
                    // Only the first stop bit is looked at
                    if (rxSample)
                        rxState <= fifoInReady ? RX_IDLE : RX_HOLD; // [R20] [R21]
                RX_HOLD:
                    // Full FIFO stalls the receiver; a start bit now is missed
                    if (fifoInReady)
                        rxState <= RX_IDLE;
                default:
                    rxState <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer, emptied when the receiver is disabled
    usx_fifo #(
        .WIDTH(CHAR_BITS_MAX),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(~cfgRxEnable),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(rxShift),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData)
    );

endmodule : usx_datapath

// *** src/usx_pkg.sv ***
// Shared constants and state types of the serial port data path.
// Assumes one 40 MHz system clock and control bits driven from the same clock.
package usx_pkg;

    // Oversampling ratios of the asynchronous bit clock
    localparam int unsigned OSR_NORMAL = 16;
    localparam int unsigned OSR_DOUBLE = 8;

    // Character size coding and bit counts
    localparam logic [2:0] CHAR_SIZE_NINE = 3'h7;
    localparam logic [2:0] CHAR_SIZE_LAST_SHORT = 3'h3;
    localparam logic [3:0] CHAR_BITS_BASE = 4'h5;
    localparam logic [3:0] CHAR_BITS_EIGHT = 4'h8;
    localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
    localparam int unsigned CHAR_BITS_MAX = 9;

    // Line levels and reset values
    localparam logic LINE_IDLE = 1'h1;
    localparam logic START_LEVEL = 1'h0;
    localparam logic DATA_EMPTY_RESET = 1'h1;
    localparam logic TX_COMPLETE_RESET = 1'h0;

    // Sizes with documented defaults
    localparam int unsigned RX_FIFO_DEPTH = 8;
    localparam int unsigned BAUD_DIV_WIDTH = 12;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} usx_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_HOLD} usx_rx_state_t;

endpackage : usx_pkg

// *** tb/tb.sv ***
// Self-checking bench for the serial data path.
// Assumes divider 0 in async mode (16 or 8 clocks a bit); sync uses divider 3.
`timescale 1ns/1ps
module tb;
    import usx_pkg::*;
    logic clk = 0, rst = 1, cfgTxEnable = 0, cfgRxEnable = 0, cfgParityEnable = 0, cfgParityOdd = 0;
    logic cfgTwoStop = 0, cfgDoubleSpeed = 0, globalIrqEnable = 1, dataEmptyIrqEnable = 1;
    logic txCompleteIrqEnable = 1, dataWrite = 0, txNinth = 0, txCompleteClear = 0, txCompleteAck = 0;
    logic rxReady = 0, dataEmpty, txComplete, irqDataEmpty, irqTxComplete, rxValid, txdOut, txdOwn, rxdIn, rxdOwn;
    logic [2:0] cfgCharSize = 0;
    logic [7:0] dataIn = 0;
    logic [BAUD_DIV_WIDTH-1:0] cfgBaudDiv = 0;
    logic [CHAR_BITS_MAX-1:0] rxData;
    logic cfgSync = 0, cfgClockMaster = 0, sckOut, sckOeN, sckToDut;
    int badCount = 0, nTests = 0, cycles = 0;

    usx_datapath usx_datapath_inst (.clk, .rst, .cfgTxEnable, .cfgRxEnable, .cfgSync,
        .cfgClockMaster, .cfgCharSize, .cfgParityEnable, .cfgParityOdd, .cfgTwoStop, .cfgDoubleSpeed,
        .cfgBaudDiv, .globalIrqEnable, .dataEmptyIrqEnable, .txCompleteIrqEnable, .dataWrite, .dataIn, .txNinth,
        .txCompleteClear, .txCompleteAck, .dataEmpty, .txComplete, .irqDataEmpty, .irqTxComplete, .rxValid,
        .rxReady, .rxData, .txdOut, .txdOwn, .rxdIn, .rxdOwn, .sckIn(sckToDut), .sckOut, .sckOeN);
    usx_peer usx_peer_inst (.clk(clk), .txd(txdOut), .sckFromDut(sckOut), .rxd(rxdIn), .sckToDut(sckToDut));

    always #12.5 clk = ~clk;

    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            badCount++;
            stopTest();
        end
    end

    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Data location writes only; the status flag position is never written
    task automatic wr(input logic [8:0] w);
        @(negedge clk);
        {txNinth, dataIn} = w;
        dataWrite = 1'h1;
        @(negedge clk);
        dataWrite = 1'h0;
    endtask : wr

    task automatic test_reset();
        check("empty", dataEmpty, DATA_EMPTY_RESET);
        check("complete", txComplete, TX_COMPLETE_RESET);
        check("own", txdOwn, 10'h0);
        check("line", txdOut, LINE_IDLE);
        check("emptyIrq", irqDataEmpty, 10'h1);
        dataEmptyIrqEnable = 1'h0;
        #1 check("emptyIrqOff", irqDataEmpty, 10'h0);
        $display("reset test done");
    endtask : test_reset

    task automatic test_tx_sizes();
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, CHAR_SIZE_NINE};
        logic [8:0] w, e;
        logic p, s;
        int n, k, i;
        cfgTxEnable = 1'h1;
        cfgParityEnable = 1'h1;
        for (k = 0; k < 5; k++)
        begin
            cfgCharSize = codes[k];
            cfgParityOdd = k[0];
            n = (codes[k] == CHAR_SIZE_NINE) ? CHAR_BITS_NINE : CHAR_BITS_BASE + codes[k];
            e = 9'h1B6 & ((9'h1 << n) - 9'h1);
            wr(9'h1B6);
            check("emptyAfterWrite", dataEmpty, 10'h0);
            usx_peer_inst.grab(n, 1'h1, w, p, s);
            check("start", s, START_LEVEL);
            check("data", w, e);
            check("parity", p, ^e ^ k[0]);
            check("emptyAfterLoad", dataEmpty, 10'h1);
            for (i = 0; i < 64 && txComplete !== 1'h1; i++)
                @(negedge clk);
            check("complete", txComplete, 10'h1);
            check("completeIrq", irqTxComplete, 10'h1);
            txCompleteAck = k[0];
            txCompleteClear = !k[0];
            @(negedge clk);
            {txCompleteAck, txCompleteClear} = 2'h0;
            check("completeCleared", txComplete, 10'h0);
        end
        $display("transmit sizes test done");
    endtask : test_tx_sizes

    task automatic test_b2b();
        logic [8:0] w;
        logic p, s;
        int i;
        cfgCharSize = 3'h3;
        cfgParityEnable = 1'h0;
        cfgTwoStop = 1'h1;
        fork
            begin
                usx_peer_inst.grab(8, 1'h0, w, p, s);
                check("first", w, 9'h05A);
                usx_peer_inst.grab(8, 1'h0, w, p, s);
                check("second", w, 9'h0C3);
                check("ownBusy", txdOwn, 10'h1);
            end
            begin
                wr(9'h05A);
                for (i = 0; i < 64 && dataEmpty !== 1'h1; i++)
                    @(negedge clk);
                wr(9'h0C3);
                cfgTxEnable = 1'h0;
            end
        join
        for (i = 0; i < 80 && txdOwn !== 1'h0; i++)
            @(negedge clk);
        check("released", txdOwn, 10'h0);
        check("idle", txdOut, LINE_IDLE);
        $display("back to back test done");
    endtask : test_b2b

    task automatic test_rx();
        logic [2:0] codes [3] = '{3'h0, CHAR_SIZE_NINE, 3'h3};
        logic [8:0] sent [3] = '{9'h1FF, 9'h155, 9'h03C};
        int n, k;
        cfgRxEnable = 1'h1;
        cfgParityEnable = 1'h1;
        #1 check("rxOwn", rxdOwn, 10'h1);
        for (k = 0; k < 3; k++)
        begin
            cfgCharSize = codes[k];
            cfgDoubleSpeed = (k == 2);
            usx_peer_inst.bitLen = (k == 2) ? OSR_DOUBLE : OSR_NORMAL;
            n = (codes[k] == CHAR_SIZE_NINE) ? CHAR_BITS_NINE : CHAR_BITS_BASE + codes[k];
            @(negedge clk);
            usx_peer_inst.send(sent[k], n, 1'h1, 1'h0);
            check("rxValid", rxValid, 10'h1);
            check("rxData", rxData, sent[k] & ((9'h1 << n) - 9'h1));
            rxReady = 1'h1;
            @(negedge clk);
            rxReady = 1'h0;
            check("rxOnce", rxValid, 10'h0);
        end
        $display("receive test done");
    endtask : test_rx

    // Sync frames both ways at once; master drives the clock pin, slave takes the peer's
    task automatic test_sync(input logic master);
        logic [8:0] w;
        cfgSync = 1'h1;
        cfgClockMaster = master;
        cfgParityEnable = 1'h0;
        cfgBaudDiv = 12'h3;
        cfgTxEnable = 1'h1;
        usx_peer_inst.slave = !master;
        usx_peer_inst.sckRun = 1'h1;
        fork
            wr(9'h0A5);
            usx_peer_inst.sync_grab(8, w);
            usx_peer_inst.sync_send(9'h03C, 8);
        join
        @(negedge clk);
        usx_peer_inst.sckRun = 1'h0;
        check("syncTx", w, 10'h0A5);
        check("sckDrive", sckOeN, master ? 10'h0 : 10'h1);
        check("syncValid", rxValid, 10'h1);
        check("syncRx", rxData, 10'h03C);
        rxReady = 1'h1;
        @(negedge clk);
        rxReady = 1'h0;
        check("syncPop", rxValid, 10'h0);
        $display("sync test done");
    endtask : test_sync

    task automatic stopTest();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stopTest

    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        test_reset();
        test_tx_sizes();
        test_b2b();
        test_rx();
        test_sync(1'h1);
        test_sync(1'h0);
        stopTest();
    end
endmodule : tb

// *** tb/usx_dp_asserts.sv ***
// Port checker for the serial data path.
// Assumes it is bound to usx_datapath and sees only its ports.
`timescale 1ns/1ps
module usx_dp_asserts
    import usx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cfgTxEnable,
    input wire logic cfgRxEnable,
    input wire logic [2:0] cfgCharSize,
    input wire logic globalIrqEnable,
    input wire logic dataEmptyIrqEnable,
    input wire logic txCompleteIrqEnable,
    input wire logic dataWrite,
    input wire logic txCompleteClear,
    input wire logic txCompleteAck,
    input wire logic dataEmpty,
    input wire logic txComplete,
    input wire logic irqDataEmpty,
    input wire logic irqTxComplete,
    input wire logic rxValid,
    input wire logic [CHAR_BITS_MAX-1:0] rxData,
    input wire logic txdOut,
    input wire logic txdOwn,
    input wire logic rxdOwn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Empty flag falls only because of a write
    write_clears_a: assert property (dataWrite |=> !dataEmpty)
        else $error("empty flag kept after write");
    empty_cause_a: assert property ($fell(dataEmpty) |-> $past(dataWrite))
        else $error("empty flag fell with no write");
    // Interrupt requests are level gates of the flags
    empty_irq_a: assert property (irqDataEmpty == (globalIrqEnable && dataEmptyIrqEnable && dataEmpty))
        else $error("empty request wrong");
    done_irq_a: assert property (irqTxComplete == (globalIrqEnable && txCompleteIrqEnable && txComplete))
        else $error("complete request wrong");
    done_set_a: assert property ($rose(txComplete) |-> dataEmpty && txdOut == LINE_IDLE)
        else $error("complete set with data pending");
    // Set wins over clear, so only test a clear of a flag already up
    done_clear_a: assert property ((txCompleteAck || txCompleteClear) && txComplete && dataEmpty |=> !txComplete)
        else $error("complete flag not cleared");
    idle_high_a: assert property (!txdOwn |-> txdOut == LINE_IDLE)
        else $error("released line not high");
    own_take_a: assert property ($rose(cfgTxEnable) |-> ##[0:2] txdOwn)
        else $error("output pin not taken");
    own_hold_a: assert property (txdOwn && !dataEmpty |=> txdOwn)
        else $error("pin released with data pending");
    rx_own_a: assert property (rxdOwn == cfgRxEnable)
        else $error("input pin ownership wrong");
    rx_upper_a: assert property (rxValid && cfgCharSize <= CHAR_SIZE_LAST_SHORT
        |-> (rxData >> (CHAR_BITS_BASE + cfgCharSize)) == '0)
        else $error("unused received bits not zero");
    reset_vals_a: assert property ($fell(rst) |-> dataEmpty && !txComplete && !txdOwn)
        else $error("wrong state after reset");
endmodule : usx_dp_asserts

bind usx_datapath usx_dp_asserts usx_dp_asserts_inst (.clk, .rst, .cfgTxEnable, .cfgRxEnable, .cfgCharSize,
    .globalIrqEnable, .dataEmptyIrqEnable, .txCompleteIrqEnable, .dataWrite, .txCompleteClear, .txCompleteAck,
    .dataEmpty, .txComplete, .irqDataEmpty, .irqTxComplete, .rxValid, .rxData, .txdOut, .txdOwn, .rxdOwn);

// *** tb/usx_peer.sv ***
// Remote serial peer: async frames, or sync frames on either side's clock.
// Assumes the bench sets bitLen, slave and sckRun directly.
`timescale 1ns/1ps
module usx_peer (
    input wire logic clk,
    input wire logic txd,
    input wire logic sckFromDut,
    output logic rxd,
    output logic sckToDut
);
    int bitLen = 16;
    bit slave = 1'b0;
    bit sckRun = 1'b0;
    wire sck = slave ? sckToDut : sckFromDut;

    initial rxd = 1'h1; // Idle line high
    initial sckToDut = 1'h0;

    // Slave clock, parked low between frames; slow enough for the synchroniser
    always
    begin
        repeat (6) @(negedge clk);
        if (sckRun || sckToDut)
            sckToDut = ~sckToDut;
    end

    // Start low, data LSB first, parity, two stops
    task automatic send(input logic [8:0] w, input int n, input logic par, input logic odd);
        int i;
        logic p;
        p = odd;
        for (i = 0; i < n; i++)
            p = p ^ w[i];
        for (i = -1; i < n + int'(par) + 2; i++)
        begin
            rxd = (i < 0) ? 1'h0 : (i < n) ? w[i] : (par && i == n) ? p : 1'h1;
            repeat (bitLen) @(negedge clk);
        end
    endtask : send

    // Mid-bit sampling; waits for the start edge
    task automatic grab(input int n, input logic par, output logic [8:0] w, output logic p, output logic s);
        int i;
        w = '0;
        p = 1'h0;
        @(negedge txd);
        repeat (bitLen / 2) @(posedge clk);
        s = txd;
        for (i = 0; i < n + int'(par); i++)
        begin
            repeat (bitLen) @(posedge clk);
            if (i < n)
                w[i] = txd;
            else
                p = txd;
        end
    endtask : grab

    // Sync frame: change after serial clock rise, two stop bits
    task automatic sync_send(input logic [8:0] w, input int n);
        int i;
        for (i = -1; i < n + 2; i++)
        begin
            @(posedge sck);
            rxd <= (i < 0) ? 1'h0 : (i < n) ? w[i] : 1'h1;
        end
    endtask : sync_send

    // Sync capture at serial clock fall, after the low start bit
    task automatic sync_grab(input int n, output logic [8:0] w);
        int i;
        w = '0;
        @(negedge sck);
        while (txd !== 1'h0)
            @(negedge sck);
        for (i = 0; i < n; i++)
        begin
            @(negedge sck);
            w[i] = txd;
        end
    endtask : sync_grab
endmodule : usx_peer
